/* File: src/rcr_regs.v */
// Purpose: APB register bank for clock dividers, event flags and tuning
// Assumes: pclk stands in for the crystal reference clock
// Notes: zero wait state APB slave, flags clear by writing one
//
// Contract
// - aux clock is reference over divider, zero off; here divider one holds high and fifteen holds low
// - gain updates every sixteen times divider cycles
// - wake count equal threshold sets flag seven
// - smart wake level above threshold sets flag
// - cipher done sets flag when module loaded
// - packet mode transmit end sets flag four
// - packet mode address match sets flag three
// - packet mode crc pass sets flag two
// - qualified sync word sets flag one
// - qualified preamble sets flag zero
// - low supply sets system flag seven
// - command processor ready sets flag six
// - wake timer expiry sets flag four
// - port ready flag one, command finished zero
// - control bit one runs synthesizer tuning
// - control bit zero runs baseband tuning
// - status bit one shows synthesizer tuned
// - status bit zero shows baseband tuned
// - tuned baseband word readable, read only
// - override enable selects software word
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "rcr_consts.vh"

module rcr_regs #(
  parameter SYNTH_CAL_CYCLES = `RCR_SYNTH_CAL_CYCLES,
  parameter BB_CAL_CYCLES = `RCR_BB_CAL_CYCLES
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire packet_mode,
  input wire smart_wake_operation,
  input wire [7:0] signal_level,
  input wire aes_module_loaded,
  input wire aes_done,
  input wire tx_end,
  input wire address_match,
  input wire crc_ok,
  input wire sync_found,
  input wire preamble_found,
  input wire battery_low,
  input wire cmd_ready,
  input wire wake_timer_tick,
  input wire port_ready,
  input wire cmd_finished,
  input wire amplifier_ramp_done,
  input wire [5:0] baseband_measured_word,
  output reg aux_clock_out_pin,
  output reg gain_update_tick,
  output reg synthesizer_tune_active,
  output reg baseband_tune_active,
  output reg [5:0] baseband_tune_word
);

  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_DONE = 3'b100;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [3:0] aux_div_reg;
  reg [7:0] gain_div_reg;
  reg [7:0] flags0_reg;
  reg [7:0] flags1_reg;
  reg [1:0] tune_ctl_reg;
  reg [6:0] word_ovr_reg;
  reg [15:0] wake_thr_reg;
  reg [7:0] level_thr_reg;
  reg [15:0] wake_cnt_reg;
  reg [5:0] cal_word_reg;
  reg ramp_done_reg;
  reg [3:0] aux_cnt_reg;
  reg [11:0] gain_cnt_reg;
  wire [1:0] tune_done;
  wire [1:0] tune_busy;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire [11:0] idx = paddr[13:2];
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready & pwrite;

  function mapped;
    input [11:0] i;
    begin
      case (i)
        `RCR_IDX_AUXDIV, `RCR_IDX_GAINDIV, `RCR_IDX_FLAGS0,
        `RCR_IDX_FLAGS1, `RCR_IDX_TUNECTL, `RCR_IDX_TUNESTAT,
        `RCR_IDX_WORDRB, `RCR_IDX_WORDOVR, `RCR_IDX_WAKETHR_LO,
        `RCR_IDX_WAKETHR_HI, `RCR_IDX_LEVELTHR, `RCR_IDX_WAKECNT_LO,
        `RCR_IDX_WAKECNT_HI:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  endfunction

  function wr_hit;
    input [11:0] i;
    begin
      wr_hit = wr_go & (idx == i);
    end
  endfunction

  reg [7:0] rd_byte;
  always @*
  begin
    case (idx)
      `RCR_IDX_AUXDIV: rd_byte = {4'h0, aux_div_reg};
      `RCR_IDX_GAINDIV: rd_byte = gain_div_reg;
      `RCR_IDX_FLAGS0: rd_byte = flags0_reg;
      `RCR_IDX_FLAGS1: rd_byte = flags1_reg;
      `RCR_IDX_TUNECTL: rd_byte = {6'h00, tune_ctl_reg};
      `RCR_IDX_TUNESTAT: rd_byte = {5'h00, ramp_done_reg, tune_done};
      `RCR_IDX_WORDRB: rd_byte = {2'h0, cal_word_reg};
      `RCR_IDX_WORDOVR: rd_byte = {1'h0, word_ovr_reg};
      `RCR_IDX_WAKETHR_LO: rd_byte = wake_thr_reg[7:0];
      `RCR_IDX_WAKETHR_HI: rd_byte = wake_thr_reg[15:8];
      `RCR_IDX_LEVELTHR: rd_byte = level_thr_reg;
      `RCR_IDX_WAKECNT_LO: rd_byte = wake_cnt_reg[7:0];
      `RCR_IDX_WAKECNT_HI: rd_byte = wake_cnt_reg[15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  // answer is staged in setup so outputs stay pure flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~(mapped(idx) & (paddr[1:0] == 2'h0));
      if (setup & ~pwrite & (paddr[1:0] == 2'h0))
        prdata <= {24'h000000, rd_byte};
      else
        prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_div_reg <= `RCR_RST_AUXDIV;
      gain_div_reg <= `RCR_RST_GAINDIV;
      tune_ctl_reg <= 2'h0;
      word_ovr_reg <= 7'h00;
      wake_thr_reg <= 16'h0000;
      level_thr_reg <= 8'h00;
    end
    else
    begin
      if (wr_hit(`RCR_IDX_AUXDIV))
        aux_div_reg <= pwdata[3:0];
      if (wr_hit(`RCR_IDX_GAINDIV))
        gain_div_reg <= pwdata[7:0];
      if (wr_hit(`RCR_IDX_TUNECTL))
        tune_ctl_reg <= pwdata[1:0];
      if (wr_hit(`RCR_IDX_WORDOVR))
        word_ovr_reg <= pwdata[6:0];
      if (wr_hit(`RCR_IDX_WAKETHR_LO))
        wake_thr_reg[7:0] <= pwdata[7:0];
      if (wr_hit(`RCR_IDX_WAKETHR_HI))
        wake_thr_reg[15:8] <= pwdata[7:0];
      if (wr_hit(`RCR_IDX_LEVELTHR))
        level_thr_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  wire [15:0] wake_cnt_next = wake_cnt_reg + 16'h0001;
  wire [7:0] set0;
  wire [7:0] set1;
  wire [7:0] clr0 = wr_hit(`RCR_IDX_FLAGS0) ? pwdata[7:0] : 8'h00;
  wire [7:0] clr1 = wr_hit(`RCR_IDX_FLAGS1) ? pwdata[7:0] : 8'h00;

  assign set0[`RCR_F0_WAKECNT] = wake_timer_tick &
    (wake_cnt_next == wake_thr_reg);
  assign set0[`RCR_F0_LEVEL] = smart_wake_operation &
    (signal_level > level_thr_reg);
  assign set0[`RCR_F0_AES] = aes_done & aes_module_loaded;
  assign set0[`RCR_F0_TXEND] = tx_end & packet_mode;
  assign set0[`RCR_F0_ADDR] = address_match & packet_mode;
  assign set0[`RCR_F0_CRC] = crc_ok & packet_mode;
  assign set0[`RCR_F0_SYNC] = sync_found;
  assign set0[`RCR_F0_PREAMBLE] = preamble_found;
  assign set1[`RCR_F1_BATT] = battery_low;
  assign set1[`RCR_F1_CMDRDY] = cmd_ready;
  assign set1[5] = 1'b0;
  assign set1[`RCR_F1_WAKETMO] = wake_timer_tick;
  assign set1[3] = 1'b0;
  assign set1[2] = 1'b0;
  assign set1[`RCR_F1_PORTRDY] = port_ready;
  assign set1[`RCR_F1_CMDFIN] = cmd_finished;

  // a new event in the clearing cycle wins over the clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags0_reg <= 8'h00;
      flags1_reg <= 8'h00;
      wake_cnt_reg <= 16'h0000;
    end
    else
    begin
      flags0_reg <= (flags0_reg & ~clr0) | set0;
      flags1_reg <= ((flags1_reg & ~clr1) | set1) &
        `RCR_F1_USED;
      if (wr_hit(`RCR_IDX_WAKECNT_LO) | wr_hit(`RCR_IDX_WAKECNT_HI))
        wake_cnt_reg <= 16'h0000;
      else if (wake_timer_tick)
        wake_cnt_reg <= wake_cnt_next;
    end
  end

  // ----------------------------------------
  // aux clock divider
  // ----------------------------------------
  // divide by one cannot toggle faster than a flop; it holds high
  wire [3:0] aux_half = (aux_div_reg + 4'h1) >> 1;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_cnt_reg <= 4'h0;
      aux_clock_out_pin <= 1'b0;
    end
    else if (aux_div_reg == 4'h0)
    begin
      aux_cnt_reg <= 4'h0;
      aux_clock_out_pin <= 1'b0;
    end
    else
    begin
      if (aux_cnt_reg >= aux_div_reg - 4'h1)
        aux_cnt_reg <= 4'h0;
      else
        aux_cnt_reg <= aux_cnt_reg + 4'h1;
      aux_clock_out_pin <= (aux_cnt_reg < aux_half);
    end
  end

  // ----------------------------------------
  // gain loop rate
  // ----------------------------------------
  wire [11:0] gain_period = {gain_div_reg, 4'h0};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_cnt_reg <= 12'h000;
      gain_update_tick <= 1'b0;
    end
    else if (gain_div_reg == 8'h00)
    begin
      gain_cnt_reg <= 12'h000;
      gain_update_tick <= 1'b0;
    end
    else if (gain_cnt_reg >= gain_period - 12'h001)
    begin
      gain_cnt_reg <= 12'h000;
      gain_update_tick <= 1'b1;
    end
    else
    begin
      gain_cnt_reg <= gain_cnt_reg + 12'h001;
      gain_update_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // tuning sequencers
  // ----------------------------------------
  // lane 0 is the baseband filter, lane 1 the synthesizer
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : lane
      reg [2:0] state_reg;
      reg [15:0] cnt_reg;
      wire [15:0] span = (g == 1) ? SYNTH_CAL_CYCLES[15:0] :
        BB_CAL_CYCLES[15:0];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          state_reg <= ST_IDLE;
          cnt_reg <= 16'h0000;
        end
        else if (!tune_ctl_reg[g])
        begin
          state_reg <= ST_IDLE;
          cnt_reg <= 16'h0000;
        end
        else
        begin
          case (state_reg)
            ST_IDLE:
            begin
              state_reg <= ST_BUSY;
              cnt_reg <= 16'h0000;
            end
            ST_BUSY:
            begin
              if (cnt_reg >= span - 16'h0001)
                state_reg <= ST_DONE;
              cnt_reg <= cnt_reg + 16'h0001;
            end
            ST_DONE:
              state_reg <= ST_DONE;
            default:
              state_reg <= ST_IDLE;
          endcase
        end
      end
      assign tune_done[g] = (state_reg == ST_DONE);
      assign tune_busy[g] = (state_reg == ST_BUSY);
    end
  endgenerate

  // ----------------------------------------
  // tuning outputs and word select
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cal_word_reg <= 6'h00;
      ramp_done_reg <= 1'b0;
      synthesizer_tune_active <= 1'b0;
      baseband_tune_active <= 1'b0;
      baseband_tune_word <= 6'h00;
    end
    else
    begin
      if (lane[0].state_reg == ST_BUSY &&
          lane[0].cnt_reg >= BB_CAL_CYCLES[15:0] - 16'h0001)
        cal_word_reg <= baseband_measured_word;
      ramp_done_reg <= amplifier_ramp_done;
      synthesizer_tune_active <= tune_busy[1];
      baseband_tune_active <= tune_busy[0];
      if (word_ovr_reg[0])
        baseband_tune_word <= word_ovr_reg[6:1];
      else
        baseband_tune_word <= cal_word_reg;
    end
  end

endmodule

/* File: src/rcr_consts.vh */
// Purpose: constants for the radio calibration and clock divider registers
// Assumes: register index times four gives the byte address
// Notes: all counts in pclk cycles
`ifndef RCR_CONSTS_VH
`define RCR_CONSTS_VH

// ----------------------------------------
// register indexes
// ----------------------------------------
`define RCR_IDX_AUXDIV 12'h32E
`define RCR_IDX_GAINDIV 12'h32F
`define RCR_IDX_FLAGS0 12'h336
`define RCR_IDX_FLAGS1 12'h337
`define RCR_IDX_TUNECTL 12'h338
`define RCR_IDX_TUNESTAT 12'h339
`define RCR_IDX_WORDRB 12'h345
`define RCR_IDX_WORDOVR 12'h346
`define RCR_IDX_WAKETHR_LO 12'h3F0
`define RCR_IDX_WAKETHR_HI 12'h3F1
`define RCR_IDX_LEVELTHR 12'h3F2
`define RCR_IDX_WAKECNT_LO 12'h3F3
`define RCR_IDX_WAKECNT_HI 12'h3F4

// ----------------------------------------
// reset values
// ----------------------------------------
`define RCR_RST_AUXDIV 4'h4
`define RCR_RST_GAINDIV 8'h28

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define RCR_F0_WAKECNT 7
`define RCR_F0_LEVEL 6
`define RCR_F0_AES 5
`define RCR_F0_TXEND 4
`define RCR_F0_ADDR 3
`define RCR_F0_CRC 2
`define RCR_F0_SYNC 1
`define RCR_F0_PREAMBLE 0
`define RCR_F1_BATT 7
`define RCR_F1_CMDRDY 6
`define RCR_F1_WAKETMO 4
`define RCR_F1_PORTRDY 1
`define RCR_F1_CMDFIN 0
`define RCR_F1_USED 8'hD3
`define RCR_GAIN_STEP 12'h010

// ----------------------------------------
// calibration durations
// ----------------------------------------
`define RCR_SYNTH_CAL_CYCLES 16'h0100
`define RCR_BB_CAL_CYCLES 16'h0200

`endif

/* File: tb/rcr_regs_assertions.sv */
// Purpose: port checks on the tuning and divider register bank
// Assumes: tuning lengths handed down by the bind
// Notes: flag bits are judged by the bench through reads
`timescale 1ns/1ns
`include "rcr_consts.vh"
module rcr_chk #(
  parameter SYNTH_CAL_CYCLES = 4,
  parameter BB_CAL_CYCLES = 4
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire gain_update_tick,
  input wire synthesizer_tune_active,
  input wire baseband_tune_active,
  input wire [5:0] baseband_tune_word
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite;
  wire ctl_wr = wr && paddr == {`RCR_IDX_TUNECTL, 2'b00};
  wire ovr_wr = wr && paddr == {`RCR_IDX_WORDOVR, 2'b00};
  reg [15:0] sc_reg;
  reg [15:0] bc_reg;
  // ----------------------------------------
  // busy run lengths, a stuck sequencer shows here
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sc_reg <= 16'h0000;
      bc_reg <= 16'h0000;
    end
    else
    begin
      sc_reg <= synthesizer_tune_active ? sc_reg + 16'h0001 : 16'h0000;
      bc_reg <= baseband_tune_active ? bc_reg + 16'h0001 : 16'h0000;
    end
  end
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  err_nodata_a: assert property (pslverr |-> pready && prdata == 0)
    else $error("error answer carries data");
  idle_bus_a: assert property (!pready |-> prdata == 0 && !pslverr)
    else $error("answer outside access cycle");
  gain_gap_a: assert property ($rose(gain_update_tick) |=> !gain_update_tick[*8])
    else $error("gain ticks too close");
  synth_len_a: assert property (synthesizer_tune_active |-> sc_reg < SYNTH_CAL_CYCLES)
    else $error("synth tuning runs too long");
  bb_len_a: assert property (baseband_tune_active |-> bc_reg < BB_CAL_CYCLES)
    else $error("baseband tuning runs too long");
  synth_off_a: assert property (ctl_wr && !pwdata[1] |-> ##2 !synthesizer_tune_active)
    else $error("synth tuning not stopped");
  bb_off_a: assert property (ctl_wr && !pwdata[0] |-> ##2 !baseband_tune_active)
    else $error("baseband tuning not stopped");
  override_use_a: assert property (ovr_wr && pwdata[0] |-> ##2
    baseband_tune_word == $past(pwdata[6:1], 2))
    else $error("override word not used");
  cover property ($fell(synthesizer_tune_active));
  cover property (pslverr);
  cover property (ovr_wr && pwdata[0]);
endmodule
bind rcr_regs rcr_chk #(.SYNTH_CAL_CYCLES(SYNTH_CAL_CYCLES),
  .BB_CAL_CYCLES(BB_CAL_CYCLES)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gain_update_tick,
  .synthesizer_tune_active, .baseband_tune_active, .baseband_tune_word);

/* File: tb/testbench.sv */
// Purpose: register level tests of the tuning and divider bank
// Assumes: short tuning lengths of four cycles
// Notes: event inputs gathered in one vector indexed like the flags
`timescale 1ns/1ns
`include "rcr_consts.vh"
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
  end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic packet_mode, smart_wake_operation, aes_module_loaded;
  logic amplifier_ramp_done, aux_clock_out_pin, gain_update_tick;
  logic synthesizer_tune_active, baseband_tune_active;
  logic [7:0] signal_level;
  logic [5:0] baseband_measured_word, baseband_tune_word;
  logic [15:0] ev;
  logic [15:0] used = 16'hD33F;
  logic [11:0] fx;
  int bad_count, checks_done, i;
  rcr_regs #(.SYNTH_CAL_CYCLES(4), .BB_CAL_CYCLES(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .packet_mode, .smart_wake_operation, .signal_level,
    .aes_module_loaded, .aes_done(ev[5]), .tx_end(ev[4]),
    .address_match(ev[3]), .crc_ok(ev[2]), .sync_found(ev[1]),
    .preamble_found(ev[0]), .battery_low(ev[15]), .cmd_ready(ev[14]),
    .wake_timer_tick(ev[12]), .port_ready(ev[9]), .cmd_finished(ev[8]),
    .amplifier_ramp_done, .baseband_measured_word, .aux_clock_out_pin,
    .gain_update_tick, .synthesizer_tune_active, .baseband_tune_active,
    .baseband_tune_word);
  always #20 pclk = ~pclk;
  // ----------------------------------------
  // bus and measuring tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] ix,
    input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    `CHK($sformatf("reg %h", ix), {24'h000000, e}, rd)
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
  endtask
  task automatic gap(input int e);
    int n;
    for (int k = 0; k < 900; k++)
    begin
      @(posedge pclk);
      if (gain_update_tick === 1'b1)
        break;
    end
    for (n = 1; n < 900; n++)
    begin
      @(posedge pclk);
      if (gain_update_tick === 1'b1)
        break;
    end
    `CHK("tick gap", e, n)
  endtask
  task automatic aux(input int e);
    int a;
    a = 0;
    repeat (48)
    begin
      @(posedge pclk);
      a += int'(aux_clock_out_pin === 1'b1);
    end
    `CHK("aux highs", e, a)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, ev} = 0;
    {smart_wake_operation, signal_level, amplifier_ramp_done} = 0;
    {packet_mode, aes_module_loaded, baseband_measured_word} = 8'hC0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc(`RCR_IDX_GAINDIV, 8'h28);
    apb(1'b1, `RCR_IDX_GAINDIV, 8'h01);
    gap(16);
    apb(1'b1, `RCR_IDX_GAINDIV, 8'h03);
    gap(48);
    rc(`RCR_IDX_AUXDIV, 8'h04);
    for (i = 0; i < 8; i++)
      rc(`RCR_IDX_FLAGS0 + i[11:0], 8'h00);
    rc(`RCR_IDX_WORDRB, 8'h00);
    rc(`RCR_IDX_WORDOVR, 8'h00);
    aux(24);
    apb(1'b1, `RCR_IDX_AUXDIV, 8'hF0);
    rc(`RCR_IDX_AUXDIV, 8'h00);
    aux(0);
    apb(1'b1, `RCR_IDX_AUXDIV, 8'h03);
    aux(32);
    apb(1'b0, 12'h3FF, 8'h00);
    `CHK("unmapped error", 1'b1, er)
    apb(1'b1, `RCR_IDX_TUNESTAT, 8'hFF);
    rc(`RCR_IDX_TUNESTAT, 8'h00);
    for (i = 0; i < 16; i++)
    begin
      if (used[i])
      begin
        pulse(i);
        fx = (i < 8) ? `RCR_IDX_FLAGS0 : `RCR_IDX_FLAGS1;
        rc(fx, 8'h01 << (i % 8));
        apb(1'b1, fx, 8'hFF);
        rc(fx, 8'h00);
      end
    end
    packet_mode <= 1'b0;
    aes_module_loaded <= 1'b0;
    for (i = 2; i < 6; i++)
      pulse(i);
    rc(`RCR_IDX_FLAGS0, 8'h00);
    apb(1'b1, `RCR_IDX_LEVELTHR, 8'h40);
    smart_wake_operation <= 1'b1;
    signal_level <= 8'h40;
    rc(`RCR_IDX_FLAGS0, 8'h00);
    signal_level <= 8'h41;
    rc(`RCR_IDX_FLAGS0, 8'h40);
    smart_wake_operation <= 1'b0;
    apb(1'b1, `RCR_IDX_FLAGS0, 8'hFF);
    apb(1'b1, `RCR_IDX_WAKETHR_LO, 8'h02);
    apb(1'b1, `RCR_IDX_WAKECNT_LO, 8'h00);
    pulse(12);
    rc(`RCR_IDX_FLAGS0, 8'h00);
    pulse(12);
    rc(`RCR_IDX_FLAGS0, 8'h80);
    amplifier_ramp_done <= 1'b1;
    baseband_measured_word <= 6'h2A;
    apb(1'b1, `RCR_IDX_TUNECTL, 8'hFF);
    rc(`RCR_IDX_TUNESTAT, 8'h04);
    repeat (4) @(posedge pclk);
    rc(`RCR_IDX_TUNESTAT, 8'h07);
    rc(`RCR_IDX_TUNECTL, 8'h03);
    baseband_measured_word <= 6'h11;
    rc(`RCR_IDX_WORDRB, 8'h2A);
    `CHK("tune word", 6'h2A, baseband_tune_word)
    apb(1'b1, `RCR_IDX_WORDOVR, 8'h2B);
    rc(`RCR_IDX_WORDOVR, 8'h2B);
    `CHK("tune word", 6'h15, baseband_tune_word)
    apb(1'b1, `RCR_IDX_WORDOVR, 8'h00);
    apb(1'b1, `RCR_IDX_TUNECTL, 8'h00);
    rc(`RCR_IDX_TUNESTAT, 8'h04);
    `CHK("tune word", 6'h2A, baseband_tune_word)
    end_of_test;
  end
  initial
  begin
    // the sequence needs well under a thousand cycles
    repeat (5000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end
endmodule
